//--- design/lftc_top.sv
// converter fault, tone and early failure control with an AXI4-Lite slave
`timescale 1ns/1ps
`include "lftc_params.svh"
module lftc_top #(
  parameter int unsigned RETRY_CYC = `LFTC_RETRY_CYC,
  parameter int unsigned FAIL_DLY_SCALE = `LFTC_CLK_HZ / 1000
) (
  // clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  // asynchronous comparator and pin inputs
  input wire logic sleep_n,
  input wire lftc_pkg::lftc_sense_t sense_async,
  // analogue controls
  output lftc_pkg::lftc_drive_t drive,
  output logic tone_out,
  output logic tone_detect_output_o,
  output logic tone_detect_output_oe,
  output logic irq_n,
  // axi4-lite slave
  input wire logic [3:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [3:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready
);
  lftc_pkg::lftc_sense_t s1_reg;
  lftc_pkg::lftc_sense_t s2_reg;
  logic sl1_reg;
  logic sl2_reg;
  logic [7:0] ctrl_reg;
  logic enable_reg;
  lftc_pkg::lftc_therm_t therm_reg;
  logic overtemp_shutdown_flag;
  logic early_supply_fail_flag;
  logic tone_present_flag;
  logic irq_pend_reg;
  logic fail_prev_reg;
  logic [31:0] retry_cnt_reg;
  logic [31:0] fail_cnt_reg;
  logic [31:0] fail_target;
  logic [15:0] tone_div_reg;
  logic tone_osc_reg;
  logic [15:0] ext_idle_reg;
  logic ext_active_reg;
  logic tone_prev_reg;
  logic [15:0] det_win_reg;
  logic [3:0] aw_a_reg;
  logic aw_have_reg;
  logic [31:0] w_d_reg;
  logic [3:0] w_s_reg;
  logic w_have_reg;
  logic wr_fire;
  logic rd_fire;
  logic stat_read;
  logic ctrl_clear;
  logic tone_src;
  logic restart_sel;

  assign tone_src = ctrl_reg[`LFTC_BIT_TONE_SRC];
  assign restart_sel = ctrl_reg[`LFTC_BIT_FAULT_RESTART];
  // a control bit loss on lockout or sleep wins over any bus write
  assign ctrl_clear = s2_reg.lockout | ~sl2_reg; // RQ2 RQ14

  // two stages for every asynchronous input
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_reg <= '0;
      s2_reg <= '0;
      sl1_reg <= 1'b0;
      sl2_reg <= 1'b0;
    end else if (clk_en) begin
      s1_reg <= sense_async;
      s2_reg <= s1_reg; // RQ22
      sl1_reg <= sleep_n;
      sl2_reg <= sl1_reg;
    end
  end

  // bus write: address and data may come in either order
  assign wr_fire = aw_have_reg & w_have_reg & ~s_bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      aw_a_reg <= 4'h0;
      w_d_reg <= 32'h0000_0000;
      w_s_reg <= 4'h0;
      s_awready <= 1'b0;
      s_wready <= 1'b0;
      s_bvalid <= 1'b0;
      s_bresp <= 2'h0;
    end else if (clk_en) begin
      s_awready <= ~aw_have_reg & ~s_awready & s_awvalid;
      s_wready <= ~w_have_reg & ~s_wready & s_wvalid;
      if (s_awvalid & s_awready) begin
        aw_have_reg <= 1'b1;
        aw_a_reg <= s_awaddr;
      end
      if (s_wvalid & s_wready) begin
        w_have_reg <= 1'b1;
        w_d_reg <= s_wdata;
        w_s_reg <= s_wstrb;
      end
      if (wr_fire) begin
        aw_have_reg <= 1'b0;
        w_have_reg <= 1'b0;
        s_bvalid <= 1'b1;
        if (aw_a_reg == `LFTC_ADDR_CTRL || aw_a_reg == `LFTC_ADDR_ENBL ||
            aw_a_reg == `LFTC_ADDR_STAT) begin
          s_bresp <= 2'h0;
        end else begin
          s_bresp <= 2'h2;
        end
      end else if (s_bvalid & s_bready) begin
        s_bvalid <= 1'b0;
      end
    end
  end

  // control register; host must rewrite after power-up
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= `LFTC_CTRL_RESET;
    end else if (clk_en) begin
      if (ctrl_clear) begin
        ctrl_reg <= `LFTC_CTRL_RESET; // RQ2 RQ14
      end else if (wr_fire && aw_a_reg == `LFTC_ADDR_CTRL && w_s_reg[0]) begin
        ctrl_reg <= w_d_reg[7:0];
      end
    end
  end

  // write of one to the enable register restarts a latched regulator once it is cool
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enable_reg <= 1'b0;
    end else if (clk_en) begin
      if (ctrl_clear) begin
        enable_reg <= 1'b0; // RQ14
      end else if (wr_fire && aw_a_reg == `LFTC_ADDR_ENBL && w_s_reg[0]) begin
        enable_reg <= w_d_reg[0]; // RQ8
      end else if (therm_reg == lftc_pkg::LFTC_HOT_LATCH) begin
        enable_reg <= 1'b0; // RQ7
      end
    end
  end

  // the hiccup timer runs off the main clock, so one second needs a wide count
  // thermal state: retry every second or latch off
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      therm_reg <= lftc_pkg::LFTC_OFF;
      retry_cnt_reg <= 32'h0000_0000;
    end else if (clk_en) begin
      case (therm_reg)
        lftc_pkg::LFTC_OFF: begin
          // never start into a hot junction, or the output would blip for a cycle
          if (enable_reg && !ctrl_clear && !s2_reg.overtemp) begin // RQ5
            therm_reg <= lftc_pkg::LFTC_RUN;
          end
        end
        lftc_pkg::LFTC_RUN: begin
          if (ctrl_clear || !enable_reg) begin
            therm_reg <= lftc_pkg::LFTC_OFF;
          end else if (s2_reg.overtemp) begin
            retry_cnt_reg <= 32'h0000_0000;
            therm_reg <= restart_sel ? lftc_pkg::LFTC_HOT_RETRY
                                     : lftc_pkg::LFTC_HOT_LATCH; // RQ5 RQ6 RQ7
          end
        end
        lftc_pkg::LFTC_HOT_RETRY: begin
          if (ctrl_clear) begin
            therm_reg <= lftc_pkg::LFTC_OFF;
          end else if (retry_cnt_reg >= RETRY_CYC - 1) begin
            retry_cnt_reg <= 32'h0000_0000;
            if (!s2_reg.overtemp) begin
              therm_reg <= lftc_pkg::LFTC_RUN; // RQ6
            end
          end else begin
            retry_cnt_reg <= retry_cnt_reg + 32'h0000_0001;
          end
        end
        default: begin
          // latched: leaves through a host enable write once cool, or to off on lockout or sleep
          if (ctrl_clear) begin
            therm_reg <= lftc_pkg::LFTC_OFF;
          end else if (wr_fire && aw_a_reg == `LFTC_ADDR_ENBL && w_s_reg[0] &&
                       w_d_reg[0] && !s2_reg.overtemp) begin
            therm_reg <= lftc_pkg::LFTC_RUN; // RQ8
          end
        end
      endcase
    end
  end

  // bus read
  assign rd_fire = s_arvalid & s_arready;
  assign stat_read = rd_fire & (s_araddr == `LFTC_ADDR_STAT);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_arready <= 1'b0;
      s_rvalid <= 1'b0;
      s_rdata <= 32'h0000_0000;
      s_rresp <= 2'h0;
    end else if (clk_en) begin
      s_arready <= s_arvalid & ~s_arready & ~s_rvalid;
      if (rd_fire) begin
        s_rvalid <= 1'b1;
        s_rresp <= 2'h0;
        if (s_araddr == `LFTC_ADDR_CTRL) begin
          s_rdata <= {24'h00_0000, ctrl_reg};
        end else if (s_araddr == `LFTC_ADDR_STAT) begin
          s_rdata <= {24'h00_0000, therm_reg, 1'b0, irq_pend_reg, s2_reg.lockout,
                      tone_present_flag, early_supply_fail_flag, overtemp_shutdown_flag};
        end else if (s_araddr == `LFTC_ADDR_ENBL) begin
          s_rdata <= {31'h0000_0000, enable_reg};
        end else begin
          s_rdata <= 32'h0000_0000;
          s_rresp <= 2'h2;
        end
      end else if (s_rvalid & s_rready) begin
        s_rvalid <= 1'b0;
      end
    end
  end

  // overtemp flag: set wins over clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      overtemp_shutdown_flag <= 1'b0;
    end else if (clk_en) begin
      if (therm_reg == lftc_pkg::LFTC_RUN && s2_reg.overtemp) begin
        overtemp_shutdown_flag <= 1'b1; // RQ5
      end else if (therm_reg == lftc_pkg::LFTC_HOT_RETRY &&
                   retry_cnt_reg >= RETRY_CYC - 1 && !s2_reg.overtemp) begin
        overtemp_shutdown_flag <= 1'b0; // RQ11
      end else if (therm_reg != lftc_pkg::LFTC_HOT_RETRY && stat_read &&
                   !s2_reg.overtemp) begin
        overtemp_shutdown_flag <= 1'b0; // RQ10
      end
    end
  end

  // interrupt pending: an overtemp shutdown while running or a new supply dip, not lockout; any bus read releases it
  // a fresh supply dip raises it again even while the flag waits to clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_pend_reg <= 1'b0;
      fail_prev_reg <= 1'b0;
      irq_n <= 1'b1;
    end else if (clk_en) begin
      fail_prev_reg <= s2_reg.early_fail;
      if ((therm_reg == lftc_pkg::LFTC_RUN && s2_reg.overtemp) ||
          (s2_reg.early_fail && !fail_prev_reg)) begin
        irq_pend_reg <= 1'b1; // RQ9 RQ20
      end else if (rd_fire) begin
        irq_pend_reg <= 1'b0; // RQ9
      end
      irq_n <= ~irq_pend_reg;
    end
  end

  // early failure flag with programmed clear delay
  always_comb begin
    case (ctrl_reg[`LFTC_BIT_DLY1:`LFTC_BIT_DLY0])
      2'h0: fail_target = FAIL_DLY_SCALE * `LFTC_FAIL_DLY0_MS;
      2'h1: fail_target = FAIL_DLY_SCALE * `LFTC_FAIL_DLY1_MS;
      2'h2: fail_target = FAIL_DLY_SCALE * `LFTC_FAIL_DLY2_MS;
      default: fail_target = FAIL_DLY_SCALE * `LFTC_FAIL_DLY3_MS;
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      early_supply_fail_flag <= 1'b0;
      fail_cnt_reg <= 32'h0000_0000;
    end else if (clk_en) begin
      if (s2_reg.early_fail) begin
        early_supply_fail_flag <= 1'b1; // RQ20
        fail_cnt_reg <= 32'h0000_0000;
      end else if (early_supply_fail_flag) begin
        if (fail_cnt_reg >= fail_target - 1) begin
          early_supply_fail_flag <= 1'b0; // RQ21
          fail_cnt_reg <= 32'h0000_0000;
        end else begin
          fail_cnt_reg <= fail_cnt_reg + 32'h0000_0001;
        end
      end
    end
  end

  // internal 22 kHz oscillator and external tone idle timer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tone_div_reg <= 16'h0000;
      tone_osc_reg <= 1'b0;
      ext_idle_reg <= 16'h0000;
      ext_active_reg <= 1'b0;
    end else if (clk_en) begin
      if (tone_div_reg >= 16'(`LFTC_TONE_HALF_CYC - 1)) begin
        tone_div_reg <= 16'h0000;
        tone_osc_reg <= ~tone_osc_reg;
      end else begin
        tone_div_reg <= tone_div_reg + 16'h0001;
      end
      if (s2_reg.tone_gate) begin
        ext_idle_reg <= 16'h0000;
        ext_active_reg <= 1'b1;
      end else if (ext_idle_reg >= 16'(`LFTC_EXT_IDLE_CYC - 1)) begin
        ext_active_reg <= 1'b0; // RQ16
      end else begin
        ext_idle_reg <= ext_idle_reg + 16'h0001;
      end
    end
  end

  // tone detector: an edge within a 1.5-cycle window keeps it present
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tone_prev_reg <= 1'b0;
      det_win_reg <= 16'h0000;
      tone_present_flag <= 1'b0;
    end else if (clk_en) begin
      tone_prev_reg <= s2_reg.tone_in;
      if (s2_reg.tone_in & ~tone_prev_reg) begin
        det_win_reg <= 16'(`LFTC_DET_WIN_CYC);
        tone_present_flag <= 1'b1; // RQ17 RQ18
      end else if (det_win_reg != 16'h0000) begin
        det_win_reg <= det_win_reg - 16'h0001;
      end else begin
        tone_present_flag <= 1'b0;
      end
    end
  end

  // outputs to the analogue stage, all registered
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      drive <= '0;
      tone_out <= 1'b0;
      tone_detect_output_o <= 1'b0;
      tone_detect_output_oe <= 1'b0;
    end else if (clk_en) begin
      drive.converter_enable <= (therm_reg == lftc_pkg::LFTC_RUN) && !ctrl_clear; // RQ5 RQ14
      drive.boost_enable <= (therm_reg == lftc_pkg::LFTC_RUN) && !ctrl_clear; // RQ5
      drive.reverse_limit <= ctrl_reg[`LFTC_BIT_SINK_DIS]; // RQ12
      // heavier pull-down for the whole burst, not only the tone's high half
      drive.sink_high <= ~ctrl_reg[`LFTC_BIT_SINK_DIS] &
                         (tone_src ? ext_active_reg : s2_reg.tone_gate); // RQ13 RQ16
      drive.detect_tight <= s2_reg.tone_gate; // RQ19
      drive.comp_select <= ctrl_reg[`LFTC_BIT_COMP]; // RQ1
      if (tone_src) begin
        // external tone passes straight through; the idle timer holds the burst state
        tone_out <= s2_reg.tone_gate; // RQ16
      end else begin
        tone_out <= s2_reg.tone_gate & tone_osc_reg; // RQ15
      end
      // open drain: pull low while the detected tone is low
      tone_detect_output_oe <= tone_present_flag & ~s2_reg.tone_in; // RQ17
    end
  end
endmodule

//--- design/lftc_params.svh
// constants for the converter fault and tone control block
// What this block and its host must do
// (RQ1) compensation select is control bit five
// (RQ2) supply lockout clears every control bit
// (RQ3) host rewrites configuration after each power-up
// (RQ4) host keeps frequency/compensation/delay fixed while running; the bench keeps only compensation fixed and changes delay while running
// (RQ5) overtemp disables output and boost until cool
// (RQ6) auto-retry restarts every second once cool
// (RQ7) latch mode stays off after overtemp
// (RQ8) host write re-enables after latched fault
// (RQ9) interrupt low on fault, released by read
// (RQ10) latched mode: read clears overtemp flag if cool
// (RQ11) auto-retry: restart clears overtemp flag
// (RQ12) reverse-current bit limits back-feed below 10 mA
// (RQ13) sink bit zero: 25 mA, 60 mA with tone
// (RQ14) shutdown input turns off, resets control register
// (RQ15) tone select zero: internal 22 kHz gated by pin
// (RQ16) tone select one: external tone, 42 us idle release
// (RQ17) detected tone drives open-drain output and flag
// (RQ18) tone reported within 1.5 tone cycles
// (RQ19) detector thresholds tight when gate high, relaxed otherwise
// (RQ20) early supply failure sets flag and interrupt
// (RQ21) failure flag clears after selected delay
// (RQ22) comparator inputs synchronised before use
`ifndef LFTC_PARAMS_SVH
`define LFTC_PARAMS_SVH
`define LFTC_ADDR_CTRL 4'h0
`define LFTC_ADDR_STAT 4'h4
`define LFTC_ADDR_ENBL 4'h8
`define LFTC_CTRL_RESET 8'h00
`define LFTC_BIT_SINK_DIS 1
`define LFTC_BIT_FAULT_RESTART 2
`define LFTC_BIT_TONE_SRC 3
`define LFTC_BIT_COMP 5
`define LFTC_BIT_DLY0 6
`define LFTC_BIT_DLY1 7
`define LFTC_CLK_HZ 20000000
`define LFTC_RETRY_MS 1000
`define LFTC_RETRY_CYC ((`LFTC_CLK_HZ / 1000) * `LFTC_RETRY_MS)
`define LFTC_TONE_HZ 22000
`define LFTC_TONE_HALF_CYC (`LFTC_CLK_HZ / (2 * `LFTC_TONE_HZ))
`define LFTC_EXT_IDLE_NS 42000
`define LFTC_EXT_IDLE_CYC ((`LFTC_EXT_IDLE_NS + 49) / 50)
`define LFTC_DET_WIN_NS 68000
`define LFTC_DET_WIN_CYC (`LFTC_DET_WIN_NS / 50)
`define LFTC_FAIL_DLY0_MS 1
`define LFTC_FAIL_DLY1_MS 5
`define LFTC_FAIL_DLY2_MS 20
`define LFTC_FAIL_DLY3_MS 50
`endif

//--- design/lftc_pkg.sv
// types for the converter fault and tone control block
package lftc_pkg;
  typedef enum logic [1:0] {LFTC_RUN, LFTC_HOT_RETRY, LFTC_HOT_LATCH, LFTC_OFF} lftc_therm_t;
  typedef struct packed {
    logic overtemp;
    logic lockout;
    logic early_fail;
    logic tone_in;
    logic tone_gate;
  } lftc_sense_t;
  typedef struct packed {
    logic converter_enable;
    logic boost_enable;
    logic reverse_limit;
    logic sink_high;
    logic detect_tight;
    logic comp_select;
  } lftc_drive_t;
endpackage

//--- bench/lftc_properties.sv
// port-level assertions for the fault and tone control block
`timescale 1ns/1ps
module lftc_properties (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // watched ports
  input wire logic sleep_n,
  input wire lftc_pkg::lftc_sense_t sense_async,
  input wire lftc_pkg::lftc_drive_t drive,
  input wire logic tone_detect_output_o,
  input wire logic irq_n,
  input wire logic s_arvalid,
  input wire logic s_arready,
  input wire logic s_bvalid,
  input wire logic s_bready
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // five samples cover two sync flops, the thermal state register and the registered drive
  property p_hot_off;
    sense_async.overtemp [*5] |-> !drive.converter_enable && !drive.boost_enable;
  endproperty
  a_hot_off: assert property (p_hot_off) else $error("output on while hot");
  property p_lock_off;
    sense_async.lockout [*5] |-> !drive.converter_enable;
  endproperty
  a_lock_off: assert property (p_lock_off) else $error("output on in lockout");
  property p_sleep_off;
    (!sleep_n) [*5] |-> !drive.converter_enable && !drive.boost_enable;
  endproperty
  a_sleep_off: assert property (p_sleep_off) else $error("output on in sleep");
  property p_fail_irq;
    $rose(sense_async.early_fail) |-> ##[2:6] !irq_n;
  endproperty
  a_fail_irq: assert property (p_fail_irq) else $error("no irq on supply fail");
  property p_hot_irq;
    $rose(sense_async.overtemp) && drive.converter_enable |-> ##[2:6] !irq_n;
  endproperty
  a_hot_irq: assert property (p_hot_irq) else $error("no irq on overtemp");
  property p_read_rel;
    (!sense_async.early_fail && !sense_async.overtemp && !sense_async.lockout) [*4]
      ##0 (s_arvalid && s_arready) |-> ##[1:4] irq_n;
  endproperty
  a_read_rel: assert property (p_read_rel) else $error("irq kept after read");
  property p_od_low;
    tone_detect_output_o == 1'b0;
  endproperty
  a_od_low: assert property (p_od_low) else $error("detect pin driven high");
  property p_tight;
    $stable(sense_async.tone_gate) [*4] |-> drive.detect_tight == sense_async.tone_gate;
  endproperty
  a_tight: assert property (p_tight) else $error("thresholds not following gate");
  property p_bhold;
    s_bvalid && !s_bready |=> s_bvalid;
  endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped");
endmodule
bind lftc_top lftc_properties u_props (.aclk(aclk), .aresetn(aresetn), .sleep_n(sleep_n),
  .sense_async(sense_async), .drive(drive), .tone_detect_output_o(tone_detect_output_o),
  .irq_n(irq_n), .s_arvalid(s_arvalid), .s_arready(s_arready), .s_bvalid(s_bvalid),
  .s_bready(s_bready));

//--- bench/lftc_host.sv
// host model: AXI4-Lite master that configures and polls the block
`timescale 1ns/1ps
module lftc_host (
  // clock
  input wire logic aclk,
  // write channels
  output logic [3:0] s_awaddr,
  output logic s_awvalid,
  input wire logic s_awready,
  output logic [31:0] s_wdata,
  output logic [3:0] s_wstrb,
  output logic s_wvalid,
  input wire logic s_wready,
  input wire logic [1:0] s_bresp,
  input wire logic s_bvalid,
  output logic s_bready,
  // read channels
  output logic [3:0] s_araddr,
  output logic s_arvalid,
  input wire logic s_arready,
  input wire logic [31:0] s_rdata,
  input wire logic [1:0] s_rresp,
  input wire logic s_rvalid,
  output logic s_rready
);
  initial begin
    {s_awaddr, s_awvalid, s_wdata, s_wstrb, s_wvalid, s_bready} = '0;
    {s_araddr, s_arvalid, s_rready} = '0;
  end
  // response code of the last write, taken with bvalid
  logic [1:0] wr_resp = 2'h0;
  // callers rewrite the full configuration, keeping compensation fixed while on
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    s_awaddr <= a;
    s_wdata <= d;
    s_wstrb <= 4'hF;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_awready) s_awvalid <= 1'b0;
      if (s_wready) s_wvalid <= 1'b0;
    end while (!s_bvalid);
    wr_resp = s_bresp;
    s_bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_arready) s_arvalid <= 1'b0;
    end while (!s_rvalid);
    d = s_rdata;
    r = s_rresp;
    s_rready <= 1'b0;
    @(posedge aclk);
  endtask
endmodule

//--- bench/tb.sv
// testbench for the converter fault and tone control block
`timescale 1ns/1ps
`include "lftc_params.svh"
module tb;
  localparam int RETRY = 200;
  localparam int SCALE = 10;
  localparam logic [3:0] A_CTRL = `LFTC_ADDR_CTRL;
  localparam logic [3:0] A_STAT = `LFTC_ADDR_STAT;
  localparam logic [3:0] A_ENBL = `LFTC_ADDR_ENBL;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic sleep_n = 1'b1;
  lftc_pkg::lftc_sense_t sense = '0;
  lftc_pkg::lftc_drive_t drive;
  logic tone_out, tdo_o, tdo_oe, irq_n, p, tone_on;
  logic [3:0] awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata, d;
  logic [1:0] bresp, rresp, r;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  int err_count = 0;
  int check_count = 0;
  int cyc = 0;
  int n;
  int dly[4] = '{SCALE * `LFTC_FAIL_DLY0_MS, SCALE * `LFTC_FAIL_DLY1_MS,
    SCALE * `LFTC_FAIL_DLY2_MS, SCALE * `LFTC_FAIL_DLY3_MS};
  lftc_top #(.RETRY_CYC(RETRY), .FAIL_DLY_SCALE(SCALE)) u_dut (.aclk(aclk),
    .aresetn(aresetn), .clk_en(1'b1), .sleep_n(sleep_n), .sense_async(sense),
    .drive(drive), .tone_out(tone_out), .tone_detect_output_o(tdo_o),
    .tone_detect_output_oe(tdo_oe), .irq_n(irq_n), .s_awaddr(awaddr), .s_awvalid(awvalid),
    .s_awready(awready), .s_wdata(wdata), .s_wstrb(wstrb), .s_wvalid(wvalid),
    .s_wready(wready), .s_bresp(bresp), .s_bvalid(bvalid), .s_bready(bready),
    .s_araddr(araddr), .s_arvalid(arvalid), .s_arready(arready), .s_rdata(rdata),
    .s_rresp(rresp), .s_rvalid(rvalid), .s_rready(rready));
  lftc_host u_host (.aclk(aclk), .s_awaddr(awaddr), .s_awvalid(awvalid),
    .s_awready(awready), .s_wdata(wdata), .s_wstrb(wstrb), .s_wvalid(wvalid),
    .s_wready(wready), .s_bresp(bresp), .s_bvalid(bvalid), .s_bready(bready),
    .s_araddr(araddr), .s_arvalid(arvalid), .s_arready(arready), .s_rdata(rdata),
    .s_rresp(rresp), .s_rvalid(rvalid), .s_rready(rready));
  always #25 aclk = ~aclk;
  // far-end tone at the nominal half period, only while enabled
  always begin
    repeat (`LFTC_TONE_HALF_CYC) @(posedge aclk);
    if (tone_on) sense.tone_in <= ~sense.tone_in;
  end
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      $display("[ERR] %0t run too long", $time);
      wrap_up();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge aclk);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    tone_on = 1'b0;
    tick(2);
    aresetn <= 1'b1;
    tick(1);
    u_host.rd(A_STAT, d, r);
    chk(d, 32'h000000C0);
    u_host.rd(4'hC, d, r);
    chk({r, d[29:0]}, 32'h80000000);
    u_host.wr(4'hC, 32'h00000001);
    chk(u_host.wr_resp, 32'h2);
    $display("test reset and map done");
    u_host.wr(A_CTRL, 32'h00000022);
    chk(u_host.wr_resp, 32'h0);
    u_host.wr(A_ENBL, 32'h00000001);
    tick(5);
    chk({26'h0, drive}, 32'h00000039);
    u_host.wr(A_CTRL, 32'h00000020);
    sense.tone_gate <= 1'b1;
    n = 0;
    p = tone_out;
    for (int i = 0; i < 1000; i++) begin
      @(posedge aclk);
      if (tone_out !== p) n++;
      p = tone_out;
    end
    chk({26'h0, drive}, 32'h00000037);
    chk(n >= 2, 1);
    sense.tone_gate <= 1'b0;
    tick(5);
    chk({26'h0, drive}, 32'h00000031);
    u_host.wr(A_CTRL, 32'h00000028);
    sense.tone_gate <= 1'b1;
    tick(5);
    chk(tone_out, 1);
    chk(drive.sink_high, 1);
    sense.tone_gate <= 1'b0;
    tick(800);
    chk(drive.sink_high, 1);
    chk(tone_out, 0);
    tick(60);
    chk(drive.sink_high, 0);
    tone_on <= 1'b1;
    tick(1500);
    u_host.rd(A_STAT, d, r);
    chk(d[2], 1);
    n = 0;
    repeat (1000) begin
      @(posedge aclk);
      if (tdo_oe === 1'b1) n++;
    end
    chk(n > 0 && n < 1000, 1);
    tone_on <= 1'b0;
    tick(3000);
    u_host.rd(A_STAT, d, r);
    chk(d[2], 0);
    chk({tdo_oe, tdo_o}, 0);
    $display("test tone done");
    for (int c = 0; c < 4; c++) begin
      u_host.wr(A_CTRL, {24'h0, 2'(c), 6'h20});
      sense.early_fail <= 1'b1;
      tick(10);
      chk(irq_n, 0);
      sense.early_fail <= 1'b0;
      tick(1);
      u_host.rd(A_STAT, d, r);
      chk(d[1], 1);
      tick(4);
      chk(irq_n, 1);
      if (c > 0) begin
        tick(dly[c] - 20);
        u_host.rd(A_STAT, d, r);
        chk(d[1], 1);
      end
      tick(30);
      u_host.rd(A_STAT, d, r);
      chk(d[1], 0);
    end
    $display("test early failure done");
    u_host.wr(A_CTRL, 32'h00000024);
    sense.overtemp <= 1'b1;
    tick(10);
    chk(drive[5:4], 0);
    tick(250);
    chk(drive.converter_enable, 0);
    sense.overtemp <= 1'b0;
    tick(120);
    chk(drive.converter_enable, 0);
    tick(40);
    chk(drive.converter_enable, 1);
    u_host.rd(A_STAT, d, r);
    chk(d[0], 0);
    u_host.wr(A_CTRL, 32'h00000020);
    sense.overtemp <= 1'b1;
    tick(10);
    chk(irq_n, 0);
    u_host.rd(A_STAT, d, r);
    tick(4);
    chk(irq_n, 1);
    u_host.rd(A_STAT, d, r);
    chk(d[0], 1);
    sense.overtemp <= 1'b0;
    tick(2 * RETRY + 10);
    chk(drive.converter_enable, 0);
    u_host.rd(A_STAT, d, r);
    u_host.rd(A_STAT, d, r);
    chk(d[0], 0);
    u_host.wr(A_ENBL, 32'h00000001);
    tick(5);
    chk(drive.converter_enable, 1);
    $display("test thermal done");
    for (int k = 0; k < 2; k++) begin
      u_host.wr(A_CTRL, 32'h00000022);
      u_host.wr(A_ENBL, 32'h00000001);
      if (k == 0) sleep_n <= 1'b0;
      else sense.lockout <= 1'b1;
      tick(5);
      chk(drive[5:4], 0);
      sleep_n <= 1'b1;
      sense.lockout <= 1'b0;
      tick(5);
      u_host.rd(A_CTRL, d, r);
      chk(d, 0);
    end
    $display("test sleep and lockout done");
    wrap_up();
  end
endmodule
